// >>> hw/ecwl_pkg.sv
`default_nettype none
package ecwl_pkg;
    // EEPROM addressing and the presence signature.
    localparam int         EE_AW     = 9;
    localparam logic [7:0] SIGNATURE = 8'hA5;
    localparam logic [8:0] SIG_ADDR  = 9'h000;
    localparam logic [4:0] IMG_BYTES = 5'h14;

    // Field positions within the configuration words.
    localparam int C1_TXC = 23, C1_RXC = 22, C1_CLK125 = 21, C1_REF25 = 20;
    localparam int C1_OVL = 18, C1_U2X = 17, C1_XTAL = 16, C1_BOUT = 12;
    localparam int C1_BIN = 8, C1_SLP = 7, C1_SWING = 6, C1_MARGIN = 3;
    localparam int C1_DEEMPH = 1, C1_EBM = 0;
    localparam int C2_U1TO = 24, C2_HIRD = 16, C2_OVL = 15, C2_U2X = 14;
    localparam int C2_ADP = 13, C2_SPDUP = 12, C2_CLKSTOP = 11, C2_EEE = 10;
    localparam int C2_LPI = 9, C2_DPX = 8, C2_SPEED = 6, C2_HSCAL = 3;
    localparam int C2_FSCAL = 0, C3_SS = 16, C3_HS = 0;
    localparam int GP_EN = 48, GP_BUF = 32, GP_DIR = 16, GP_DAT = 0;

    // Masks that strip reserved positions from each word.
    localparam logic [31:0] C1_MASK = 32'h00F7FFFF;
    localparam logic [31:0] C2_MASK = 32'hFF1FFFFF;
    localparam logic [31:0] C3_MASK = 32'hFFFFFFFF;
    localparam logic [31:0] GP_MASK = 32'h0FFF0FFF;

    // Register byte offsets and bit positions.
    localparam logic [11:0] A_CTRL = 12'h000, A_STAT = 12'h004;
    localparam logic [11:0] A_CFG1 = 12'h008, A_CFG2 = 12'h00C;
    localparam logic [11:0] A_CFG3 = 12'h010, A_GPLO = 12'h014;
    localparam logic [11:0] A_GPHI = 12'h018;
    localparam int CTRL_RELOAD = 0, CTRL_W2WINS = 1;
    localparam int ST_BUSY = 0, ST_DONE = 1, ST_SIGOK = 2, ST_ERR = 3;
    localparam int ST_BUILTIN = 4;

    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_REQ   = 3'b001,
        S_CHECK = 3'b010,
        S_APPLY = 3'b011,
        S_BOOT  = 3'b100
    } ecwl_state_e;

    typedef struct packed {logic txc_delay_en; logic rxc_delay_en;}
        ecwl_rgmii_s;
    typedef struct packed {
        logic gen_125mhz_clock_enable;
        logic ref_25mhz_out_enable;
        logic lowpower_link_up_speedup;
    } ecwl_hwcfg_s;
    typedef struct packed {logic crystal_suspend_disable;} ecwl_pmt_s;
    typedef struct packed {
        logic       lfps_overlap_check_enable;
        logic       deep_idle_exit_lfps;
        logic [3:0] bulk_out_burst_default;
        logic [3:0] bulk_in_burst_default;
        logic       utmi_sleep_enable;
        logic [4:0] resume_duration_threshold;
    } ecwl_usba_s;
    typedef struct packed {
        logic [7:0] shallow_idle_timeout;
        logic [2:0] highspeed_timeout_cal;
        logic [2:0] fullspeed_timeout_cal;
    } ecwl_usbb_s;
    typedef struct packed {
        logic [15:0] superspeed_detach_time;
        logic [15:0] highspeed_detach_time;
    } ecwl_usbc_s;
    typedef struct packed {
        logic       tx_swing_select;
        logic [2:0] tx_margin_select;
        logic [1:0] tx_deemph_select;
        logic       elastic_buf_mode;
    } ecwl_pipe_s;
    typedef struct packed {
        logic       auto_duplex_polarity;
        logic       lowpower_tx_clock_stop_enable;
        logic       energy_efficient_enable;
        logic       tx_idle_auto_removal_enable;
        logic       duplex_select;
        logic [1:0] speed_config;
    } ecwl_maccr_s;
    typedef struct packed {logic [11:0] direction; logic [11:0] data;}
        ecwl_gpioa_s;
    typedef struct packed {logic [11:0] enable; logic [11:0] buffer_type;}
        ecwl_gpiob_s;
    typedef struct packed {logic req; logic [EE_AW-1:0] addr;} ecwl_ee_cmd_s;
    typedef struct packed {logic ack; logic err; logic [7:0] data;}
        ecwl_ee_rsp_s;

    typedef struct packed {
        ecwl_state_e      st;
        logic [4:0]       idx;
        logic [7:0]       sig;
        logic [159:0]     img;
        logic [EE_AW-1:0] addr;
        logic             done;
        logic             sig_valid;
        logic             rd_err;
        logic             builtin;
        logic             word2_wins;
        logic [31:0]      rdata;
        logic [1:0]       deemph_drv;
        ecwl_rgmii_s      rgmii;
        ecwl_hwcfg_s      hwcfg;
        ecwl_pmt_s        pmt;
        ecwl_usba_s       usba;
        ecwl_usbb_s       usbb;
        ecwl_usbc_s       usbc;
        ecwl_pipe_s       pipe;
        ecwl_maccr_s      maccr;
        ecwl_gpioa_s      gpioa;
        ecwl_gpiob_s      gpiob;
    } ecwl_regs_s;

    // Reset image: every control field at its hardware default of zero.
    localparam ecwl_regs_s STATE_RST =
        '{st: S_BOOT, builtin: 1'b1, default: '0};
endpackage
`default_nettype wire

// >>> hw/ecwl_loader.sv
`default_nettype none
module ecwl_loader #(
    parameter logic [ecwl_pkg::EE_AW-1:0] IMG_BASE = 9'h004
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    output ecwl_pkg::ecwl_ee_cmd_s      ee_cmd,
    input  wire ecwl_pkg::ecwl_ee_rsp_s ee_rsp,
    input  wire logic                   otp_configured,
    input  wire logic                   compliance_mode,
    input  wire logic [1:0]             ltssm_deemph,
    output logic [1:0]                  pipe_tx_deemph,
    output logic                        desc_builtin,
    output ecwl_pkg::ecwl_rgmii_s       mac_rgmii_delay_reg,
    output ecwl_pkg::ecwl_hwcfg_s       hardware_config_reg,
    output ecwl_pkg::ecwl_pmt_s         power_mgmt_control_reg,
    output ecwl_pkg::ecwl_usba_s        usb_config_reg_a,
    output ecwl_pkg::ecwl_usbb_s        usb_config_reg_b,
    output ecwl_pkg::ecwl_usbc_s        usb_config_reg_c,
    output ecwl_pkg::ecwl_pipe_s        phy_interface_control_reg,
    output ecwl_pkg::ecwl_maccr_s       mac_control_reg,
    output ecwl_pkg::ecwl_gpioa_s       gpio_config_reg_a,
    output ecwl_pkg::ecwl_gpiob_s       gpio_config_reg_b
);
    import ecwl_pkg::*;

    ecwl_regs_s  r_reg;
    ecwl_regs_s  r_next;
    logic [31:0] w1;
    logic [31:0] w2;
    logic [31:0] w3;
    logic [31:0] gp_lo;
    logic [31:0] gp_hi;
    logic        apb_setup;
    logic        apb_access;

    // One 32-bit word of the captured image, word 0 being flags 1.
    function automatic logic [31:0] img_word(input logic [159:0] img,
                                             input int n);
        img_word = img[32*n +: 32];
    endfunction

    // True for every offset that the register map decodes.
    function automatic logic reg_hit(input logic [11:0] a);
        reg_hit = (a == A_CTRL) || (a == A_STAT) || (a == A_CFG1) ||
                  (a == A_CFG2) || (a == A_CFG3) || (a == A_GPLO) ||
                  (a == A_GPHI);
    endfunction

    // Captured words with reserved positions forced to zero.
    assign w1    = img_word(r_reg.img, 0) & C1_MASK;
    assign w2    = img_word(r_reg.img, 1) & C2_MASK;
    assign w3    = img_word(r_reg.img, 2) & C3_MASK;
    assign gp_lo = img_word(r_reg.img, 3) & GP_MASK;
    assign gp_hi = img_word(r_reg.img, 4) & GP_MASK;

    assign apb_setup  = psel && !penable;
    assign apb_access = psel && penable;

    // Read view of the register map; the image words read back masked.
    function automatic logic [31:0] reg_read(input ecwl_regs_s s,
                                             input logic [11:0] a);
        logic [31:0] v;
        v = 32'h0;
        case (a)
            A_CTRL: v[CTRL_W2WINS] = s.word2_wins;
            A_STAT:
            begin
                v[ST_BUSY]    = (s.st != S_IDLE);
                v[ST_DONE]    = s.done;
                v[ST_SIGOK]   = s.sig_valid;
                v[ST_ERR]     = s.rd_err;
                v[ST_BUILTIN] = s.builtin;
            end
            A_CFG1: v = w1;
            A_CFG2: v = w2;
            A_CFG3: v = w3;
            A_GPLO: v = gp_lo;
            A_GPHI: v = gp_hi;
            default: v = 32'h0;
        endcase
        reg_read = v;
    endfunction

    // Next-state logic: fetch sequencer, field loader and APB slave.
    always_comb
    begin
        r_next = r_reg;
        case (r_reg.st)
            S_BOOT:
            begin
                // A fresh load starts at the signature byte.
                r_next.idx    = 5'h00;
                r_next.addr   = SIG_ADDR;
                r_next.done   = 1'b0;
                r_next.rd_err = 1'b0;
                r_next.st     = S_REQ;
            end
            S_REQ:
            begin
                if (ee_rsp.ack && ee_rsp.err)
                begin
                    // A failed read ends the load with nothing applied.
                    r_next.rd_err = 1'b1;
                    r_next.done   = 1'b1;
                    r_next.st     = S_IDLE;
                end
                else if (ee_rsp.ack && r_reg.idx == 5'h00)
                begin
                    r_next.sig = ee_rsp.data;
                    r_next.st  = S_CHECK;
                end
                else if (ee_rsp.ack)
                begin
                    r_next.img[{r_reg.idx - 5'h01, 3'b000} +: 8] =
                        ee_rsp.data;
                    if (r_reg.idx == IMG_BYTES)
                    begin
                        r_next.st = S_APPLY;
                    end
                    else
                    begin
                        r_next.idx  = r_reg.idx + 5'h01;
                        r_next.addr = r_reg.addr + 9'h001;
                    end
                end
            end
            S_CHECK:
            begin
                if (r_reg.sig == SIGNATURE)
                begin
                    r_next.sig_valid = 1'b1;
                    r_next.builtin   = 1'b0;
                    r_next.idx       = 5'h01;
                    r_next.addr      = IMG_BASE;
                    r_next.st        = S_REQ;
                end
                else
                begin
                    // No EEPROM: control fields stay untouched, and the
                    // identity fields fall back to built-in descriptors
                    // unless the OTP store carries its own.
                    r_next.sig_valid = 1'b0;
                    r_next.builtin   = !otp_configured;
                    r_next.done      = 1'b1;
                    r_next.st        = S_IDLE;
                end
            end
            S_APPLY:
            begin
                r_next.rgmii.txc_delay_en = w1[C1_TXC];
                r_next.rgmii.rxc_delay_en = w1[C1_RXC];
                r_next.hwcfg.gen_125mhz_clock_enable =
                    w1[C1_CLK125];
                r_next.hwcfg.ref_25mhz_out_enable = w1[C1_REF25];
                r_next.hwcfg.lowpower_link_up_speedup =
                    w2[C2_SPDUP];
                // Word 2 holds a second copy of two USB controls; the
                // word2_wins control picks it, otherwise word 1 wins.
                r_next.usba.lfps_overlap_check_enable = r_reg.word2_wins ?
                    w2[C2_OVL] : w1[C1_OVL];
                r_next.usba.deep_idle_exit_lfps = r_reg.word2_wins ?
                    w2[C2_U2X] : w1[C1_U2X];
                r_next.pmt.crystal_suspend_disable = w1[C1_XTAL];
                r_next.usba.bulk_out_burst_default =
                    w1[C1_BOUT +: 4];
                r_next.usba.bulk_in_burst_default =
                    w1[C1_BIN +: 4];
                r_next.usba.utmi_sleep_enable = w1[C1_SLP];
                r_next.usba.resume_duration_threshold =
                    w2[C2_HIRD +: 5];
                r_next.pipe.tx_swing_select  = w1[C1_SWING];
                r_next.pipe.tx_margin_select =
                    w1[C1_MARGIN +: 3];
                r_next.pipe.tx_deemph_select =
                    w1[C1_DEEMPH +: 2];
                // Loaded from flags 1 bit 0 like the PIPE transmit fields,
                // and driven out with them on phy_interface_control_reg.
                r_next.pipe.elastic_buf_mode = w1[C1_EBM];
                r_next.usbb.shallow_idle_timeout =
                    w2[C2_U1TO +: 8];
                r_next.usbb.highspeed_timeout_cal =
                    w2[C2_HSCAL +: 3];
                r_next.usbb.fullspeed_timeout_cal =
                    w2[C2_FSCAL +: 3];
                r_next.maccr.auto_duplex_polarity = w2[C2_ADP];
                r_next.maccr.lowpower_tx_clock_stop_enable =
                    w2[C2_CLKSTOP];
                r_next.maccr.energy_efficient_enable =
                    w2[C2_EEE];
                r_next.maccr.tx_idle_auto_removal_enable =
                    w2[C2_LPI];
                r_next.maccr.duplex_select = w2[C2_DPX];
                r_next.maccr.speed_config = w2[C2_SPEED +: 2];
                r_next.usbc.superspeed_detach_time =
                    w3[C3_SS +: 16];
                r_next.usbc.highspeed_detach_time =
                    w3[C3_HS +: 16];
                r_next.gpiob.enable      = gp_hi[GP_EN - 32 +: 12];
                r_next.gpiob.buffer_type = gp_hi[GP_BUF - 32 +: 12];
                r_next.gpioa.direction   = gp_lo[GP_DIR +: 12];
                r_next.gpioa.data        = gp_lo[GP_DAT +: 12];
                r_next.done = 1'b1;
                r_next.st   = S_IDLE;
            end
            S_IDLE:
            begin
                r_next.st = S_IDLE;
            end
            default:
            begin
                r_next.st = S_IDLE;
            end
        endcase

        // Compliance mode hands de-emphasis to the link state machine.
        r_next.deemph_drv = compliance_mode ? ltssm_deemph :
            r_reg.pipe.tx_deemph_select;

        // Read data is captured in the setup cycle so it leaves a flop.
        if (apb_setup)
        begin
            r_next.rdata = reg_hit(paddr) ? reg_read(r_reg, paddr) : 32'h0;
        end

        // A reload asked for while a load runs is dropped on purpose.
        if (apb_access && pwrite && paddr == A_CTRL)
        begin
            r_next.word2_wins = pwdata[CTRL_W2WINS];
            if (pwdata[CTRL_RELOAD] && r_reg.st == S_IDLE)
            begin
                r_next.st = S_BOOT;
            end
        end
    end

    // The whole block state sits in one register.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r_reg <= STATE_RST;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // The slave never waits; unmapped offsets answer with an error.
    assign pready  = 1'b1;
    assign pslverr = apb_access && !reg_hit(paddr);
    assign prdata  = r_reg.rdata;

    assign ee_cmd.req  = (r_reg.st == S_REQ);
    assign ee_cmd.addr = r_reg.addr;

    assign pipe_tx_deemph            = r_reg.deemph_drv;
    assign desc_builtin              = r_reg.builtin;
    assign mac_rgmii_delay_reg       = r_reg.rgmii;
    assign hardware_config_reg       = r_reg.hwcfg;
    assign power_mgmt_control_reg    = r_reg.pmt;
    assign usb_config_reg_a          = r_reg.usba;
    assign usb_config_reg_b          = r_reg.usbb;
    assign usb_config_reg_c          = r_reg.usbc;
    assign phy_interface_control_reg = r_reg.pipe;
    assign mac_control_reg           = r_reg.maccr;
    assign gpio_config_reg_a         = r_reg.gpioa;
    assign gpio_config_reg_b         = r_reg.gpiob;

    // Checks on the loader, all in the pclk domain.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence apply_s;
        r_reg.st == S_APPLY;
    endsequence

    sequence sig_bad_s;
        r_reg.st == S_CHECK && r_reg.sig != SIGNATURE;
    endsequence

    sig_reject_a: assert property (
        sig_bad_s |=> r_reg.st == S_IDLE && !r_reg.sig_valid && r_reg.done)
        else $error("Bad signature did not end the load.");
    sig_accept_a: assert property (
        r_reg.st == S_CHECK && r_reg.sig == SIGNATURE
        |=> ee_cmd.req && ee_cmd.addr == IMG_BASE)
        else $error("Good signature did not start the image fetch.");
    defaults_kept_a: assert property (
        sig_bad_s |=> $stable(mac_control_reg) && $stable(usb_config_reg_a)
        && $stable(gpio_config_reg_a) && $stable(phy_interface_control_reg))
        else $error("Control register changed without a signature.");
    builtin_desc_a: assert property (
        sig_bad_s and !otp_configured |=> desc_builtin)
        else $error("Built-in descriptors not selected.");
    rgmii_load_a: assert property (
        apply_s |=> mac_rgmii_delay_reg ==
        {$past(r_reg.img[C1_TXC]), $past(r_reg.img[C1_RXC])})
        else $error("RGMII delays not loaded from flags 1.");
    burst_load_a: assert property (
        apply_s |=> usb_config_reg_a.bulk_out_burst_default ==
        $past(r_reg.img[15:12]) &&
        usb_config_reg_a.bulk_in_burst_default == $past(r_reg.img[11:8]))
        else $error("Burst sizes not loaded from flags 1.");
    deemph_mux_a: assert property (
        compliance_mode |=> pipe_tx_deemph == $past(ltssm_deemph))
        else $error("Compliance de-emphasis not taken from the link.");
    mac_load_a: assert property (
        apply_s |=> mac_control_reg.speed_config == $past(r_reg.img[39:38])
        && mac_control_reg.duplex_select == $past(r_reg.img[40]))
        else $error("MAC speed or duplex not loaded from flags 2.");
    detach_load_a: assert property (
        apply_s |=> usb_config_reg_c == $past(r_reg.img[95:64]))
        else $error("Detach times not loaded from flags 3.");
    gpio_load_a: assert property (
        apply_s |=> gpio_config_reg_b.enable == $past(r_reg.img[155:144])
        && gpio_config_reg_a.data == $past(r_reg.img[107:96]))
        else $error("GPIO defaults not loaded.");
    word2_pick_a: assert property (
        apply_s and r_reg.word2_wins |=>
        usb_config_reg_a.lfps_overlap_check_enable == $past(r_reg.img[47]))
        else $error("Word 2 LFPS copy did not prevail.");

    // Field loads other than GPIO direction and buffer type, deep_idle_exit_lfps and the word 1 LFPS copy
    // are held against their raw image bits, so a wrong position constant in the package shows up here as well as in a test.
    hwcfg_load_a: assert property (
        apply_s |=> hardware_config_reg.gen_125mhz_clock_enable ==
        $past(r_reg.img[21]) &&
        hardware_config_reg.ref_25mhz_out_enable == $past(r_reg.img[20]))
        else $error("Clock enables not loaded from flags 1.");
    crystal_load_a: assert property (
        apply_s |=> power_mgmt_control_reg == $past(r_reg.img[16]))
        else $error("Crystal suspend control not loaded.");
    sleep_load_a: assert property (
        apply_s |=> usb_config_reg_a.utmi_sleep_enable ==
        $past(r_reg.img[7]))
        else $error("UTMI sleep enable not loaded from flags 1.");
    pipe_load_a: assert property (
        apply_s |=> phy_interface_control_reg == $past(r_reg.img[6:0]))
        else $error("PIPE transmit fields not loaded from flags 1.");
    idle_timer_a: assert property (
        apply_s |=> usb_config_reg_b.shallow_idle_timeout ==
        $past(r_reg.img[63:56]) &&
        usb_config_reg_a.resume_duration_threshold == $past(r_reg.img[52:48]))
        else $error("U1 timeout or resume threshold not loaded.");
    mac_eee_a: assert property (
        apply_s |=> mac_control_reg[6:3] ==
        $past({r_reg.img[45], r_reg.img[43:41]}))
        else $error("MAC polarity or low-power bits not loaded.");
    speedup_load_a: assert property (
        apply_s |=> hardware_config_reg.lowpower_link_up_speedup ==
        $past(r_reg.img[44]))
        else $error("Link-up speed-up not loaded from flags 2.");
    tocal_load_a: assert property (
        apply_s |=> usb_config_reg_b[5:0] == $past(r_reg.img[37:32]))
        else $error("Timeout calibrations not loaded from flags 2.");
    req_hold_a: assert property (
        ee_cmd.req && !ee_rsp.ack |=> ee_cmd.req && $stable(ee_cmd.addr))
        else $error("EEPROM request dropped before its answer.");
endmodule
`default_nettype wire

// >>> tb/ecwl_ee_model.sv
`default_nettype none
module ecwl_ee_model (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire ecwl_pkg::ecwl_ee_cmd_s ee_cmd,
    output ecwl_pkg::ecwl_ee_rsp_s      ee_rsp,
    input  wire logic [3:0]             lat
);
    timeunit 1ns;
    timeprecision 1ps;
    import ecwl_pkg::*;
    logic [7:0] mem [512];
    logic [3:0] cnt;
    // Set by the bench: one address answers with a read error.
    logic       fail_en;
    logic [8:0] fail_addr;

    // Answers a byte after lat idle cycles; between answers the data lines
    // toggle, so the loader can never reuse a stale byte by accident.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ee_rsp <= '0;
            cnt <= '0;
        end
        else if (ee_cmd.req && !ee_rsp.ack && cnt >= lat)
        begin
            ee_rsp <= '{1'b1, fail_en && ee_cmd.addr == fail_addr,
                        mem[ee_cmd.addr]};
            cnt <= '0;
        end
        else
        begin
            ee_rsp <= '{1'b0, 1'b0, ~ee_rsp.data};
            cnt <= ee_cmd.req ? cnt + 4'h1 : 4'h0;
        end
    end
endmodule
`default_nettype wire

// >>> tb/test_eeprom_config_word_loader.sv
`default_nettype none
module test_eeprom_config_word_loader;
    timeunit 1ns;
    timeprecision 1ps;
    import ecwl_pkg::*;
    typedef struct packed {
        logic [31:0] f1, f2, f3;
        logic [63:0] gp;
        logic        w2;
        logic [3:0]  lat;
    } ecwl_row_s;
    localparam logic [8:0] IMG = 9'h010;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic        otp_configured, compliance_mode, desc_builtin;
    logic [1:0]  ltssm_deemph, pipe_tx_deemph;
    logic [3:0]  lat;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int          error_cnt, total_checks;
    ecwl_ee_cmd_s ee_cmd;
    ecwl_ee_rsp_s ee_rsp;
    ecwl_rgmii_s  mac_rgmii_delay_reg;
    ecwl_hwcfg_s  hardware_config_reg;
    ecwl_pmt_s    power_mgmt_control_reg;
    ecwl_usba_s   usb_config_reg_a;
    ecwl_usbb_s   usb_config_reg_b;
    ecwl_usbc_s   usb_config_reg_c;
    ecwl_pipe_s   phy_interface_control_reg;
    ecwl_maccr_s  mac_control_reg;
    ecwl_gpioa_s  gpio_config_reg_a;
    ecwl_gpiob_s  gpio_config_reg_b;
    // Reserved bits are set in most rows, so any leak shows in a register.
    ecwl_row_s rows [4] = '{
        '{'1, '1, '1, '1, 1'b0, 4'h0},
        '{32'h12345678, 32'h9ABCDEF0, 32'h0F1E2D3C,
          64'h5A5AA5A53C3CC3C3, 1'b1, 4'h3},
        '{'0, '0, '0, '0, 1'b1, 4'h1},
        '{32'hEDCBA987, 32'h65432110, 32'hF0E1D2C3,
          64'hA5A55A5AC3C33C3C, 1'b0, 4'h2}};

    ecwl_loader #(.IMG_BASE(IMG)) i_dut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ee_cmd,
        .ee_rsp, .otp_configured, .compliance_mode, .ltssm_deemph,
        .pipe_tx_deemph, .desc_builtin, .mac_rgmii_delay_reg,
        .hardware_config_reg, .power_mgmt_control_reg, .usb_config_reg_a,
        .usb_config_reg_b, .usb_config_reg_c, .phy_interface_control_reg,
        .mac_control_reg, .gpio_config_reg_a, .gpio_config_reg_b);
    ecwl_ee_model m (.pclk, .presetn, .ee_cmd, .ee_rsp, .lat);

    // Free-running 200 MHz clock.
    always #2.5 pclk = ~pclk;

    task automatic tally_and_finish();
        if (error_cnt == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // One APB transfer; an idle edge follows so psel never toggles twice
    // in one time step between transfers.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (n == 20)
        begin
            // A slave that never answers ends the run as a failure.
            error_cnt++;
            tally_and_finish();
        end
        else
        begin
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
            if (pready !== 1'b1)
                error_cnt++;
        end
    endtask

    // Polls status until done and not busy; a hang ends the run.
    task automatic wait_done();
        for (int n = 0; n < 200; n++)
        begin
            apb(1'b0, 12'h004, '0);
            if (rd[1:0] === 2'b10)
                return;
        end
        error_cnt++;
        tally_and_finish();
    endtask

    task automatic check_all(input ecwl_row_s r, input logic b);
        logic o, u;
        o = r.w2 ? r.f2[15] : r.f1[18];
        u = r.w2 ? r.f2[14] : r.f1[17];
        check(mac_rgmii_delay_reg, r.f1[23:22]);
        check(hardware_config_reg, {r.f1[21:20], r.f2[12]});
        check(power_mgmt_control_reg, r.f1[16]);
        check(usb_config_reg_a, {o, u, r.f1[15:7], r.f2[20:16]});
        check(usb_config_reg_a[15:14], {o, u});
        check(usb_config_reg_a[13:5], r.f1[15:7]);
        check(usb_config_reg_b, {r.f2[31:24], r.f2[5:0]});
        check(usb_config_reg_c, r.f3);
        check(phy_interface_control_reg, r.f1[6:0]);
        check(pipe_tx_deemph, r.f1[2:1]);
        check(mac_control_reg, {r.f2[13], r.f2[11:6]});
        check(gpio_config_reg_a, {r.gp[27:16], r.gp[11:0]});
        check(gpio_config_reg_b, {r.gp[59:48], r.gp[43:32]});
        check(desc_builtin, b);
    endtask

    // Rows first, then a read error in the image, bad signature with and without
    // OTP, compliance override and an unmapped access.
    initial
    begin
        {pclk, presetn, psel, penable, pwrite, lat} = '0;
        {otp_configured, compliance_mode, ltssm_deemph} = '0;
        {paddr, pwdata, error_cnt, total_checks} = '0;
        for (int i = 0; i < 512; i++)
            m.mem[i] = 8'h00;
        m.mem[0] = 8'hA5;
        m.fail_en = 1'b0;
        m.fail_addr = 9'h000;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        wait_done();
        foreach (rows[i])
        begin
            for (int k = 0; k < 20; k++)
                m.mem[IMG + k] = {rows[i].gp, rows[i].f3, rows[i].f2,
                                  rows[i].f1} >> (8 * k);
            lat <= rows[i].lat;
            apb(1'b1, 12'h000, {30'h0, rows[i].w2, 1'b1});
            wait_done();
            check(rd[4:0], 5'h06);
            check_all(rows[i], 1'b0);
            apb(1'b0, A_GPHI, '0);
            check(rd, rows[i].gp[63:32] & GP_MASK);
        end
        // A read error inside the image must leave the last load intact.
        m.fail_en = 1'b1;
        m.fail_addr = IMG + 9'h005;
        apb(1'b1, A_CTRL, 32'h1);
        wait_done();
        check(rd[4:0], 5'h0E);
        check_all(rows[3], 1'b0);
        m.fail_en = 1'b0;
        m.mem[0] = 8'h5A;
        for (int b = 0; b < 2; b++)
        begin
            otp_configured <= b[0];
            presetn <= 1'b0;
            repeat (3) @(posedge pclk);
            check({usb_config_reg_c, gpio_config_reg_b}, 56'h0);
            check(desc_builtin, 1'b1);
            presetn <= 1'b1;
            wait_done();
            check(rd[2], 1'b0);
            check_all('0, !b[0]);
        end
        compliance_mode <= 1'b1;
        ltssm_deemph <= 2'b10;
        repeat (2) @(posedge pclk);
        check(pipe_tx_deemph, 2'b10);
        apb(1'b0, 12'hFFC, '0);
        check({er, rd}, {1'b1, 32'h0});
        tally_and_finish();
    end
endmodule
`default_nettype wire
